// ===== nand_host.sv
`timescale 1ns/1ns
`default_nettype none
module nand_host (
  // Clock
  input wire logic pclk,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic link_clk,
  output logic [7:0] dq_in,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe
);
  initial {ce_n, cle, ale, we_n, re_n, link_clk} = 6'b100110;
  initial dq_in = 8'hA5;
  // Parked bus shows the inverse so a stale byte is never latched
  task automatic latch(input logic is_cmd, input logic [7:0] b);
    @(posedge pclk);
    ce_n <= 1'b0;
    cle <= is_cmd;
    ale <= !is_cmd;
    dq_in <= b;
    we_n <= 1'b0;
    repeat (4) @(posedge pclk);
    we_n <= 1'b1;
    repeat (4) @(posedge pclk);
    cle <= 1'b0;
    ale <= 1'b0;
    dq_in <= ~b;
  endtask
  // only the column pair, never cache select
  task automatic col(input logic [12:0] c);
    latch(1'b1, 8'h05);
    latch(1'b0, c[7:0]);
    latch(1'b0, {3'h0, c[12:8]});
    latch(1'b1, 8'hE0);
  endtask
  task automatic rd(output logic [7:0] b);
    @(posedge pclk);
    ce_n <= 1'b0;
    re_n <= 1'b0;
    repeat (6) @(posedge pclk);
    // Released bus reads as the inverse of the last byte
    b = dq_oe ? dq_out : ~dq_out;
    re_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // Link clock runs only inside the burst
  task automatic ddr(input int n);
    @(posedge pclk);
    ce_n <= 1'b0;
    re_n <= 1'b0;
    repeat (n) begin
      repeat (4) @(posedge pclk);
      link_clk <= ~link_clk;
    end
    repeat (8) @(posedge pclk);
    re_n <= 1'b1;
    ce_n <= 1'b1;
  endtask
endmodule // nand_host
`default_nettype wire

// ===== sync2.v
`timescale 1ns/1ns
`default_nettype none

module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // Data
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule // sync2

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "uid_param_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  localparam logic [127:0] UID = 128'hF0E1D2C3_B4A59687_78695A4B_3C2D1E0F;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic lun_busy = 1'b0;
  logic clk_en = 1'b1;
  wire pready, pslverr, dq_oe, dqs_out, dqs_oe, rb_out, rb_oe, ce_n, cle, ale, we_n, re_n, link_clk;
  wire [31:0] prdata;
  wire [7:0] dq_in, dq_out;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] rd_d;
  logic rd_e;
  logic [7:0] b;
  logic [7:0] strobed[$];
  logic dqs_q = 1'b0;
  always #5 pclk = ~pclk;
  uid_param_readout #(.TR_CYCLES(20)) u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .lun_busy, .ce_n, .cle, .ale, .we_n, .re_n, .link_clk, .dq_in, .dq_out,
    .dq_oe, .dqs_out, .dqs_oe, .rb_out, .rb_oe);
  nand_host u_host (.pclk, .ce_n, .cle, .ale, .we_n, .re_n, .link_clk, .dq_in, .dq_out, .dq_oe);
  always @(posedge pclk) begin
    dqs_q <= dqs_out;
    if (dqs_oe === 1'b1 && dqs_out !== dqs_q) strobed.push_back(dq_out);
  end
  // ----
  // Helpers
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready(input logic busy);
    int i;
    i = 0;
    while (rb_oe !== 1'b1 && i < 30) begin
      @(posedge pclk);
      i++;
    end
    `CHK(rb_oe, busy)
    while (rb_oe !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic [7:0] uid_byte(input int c);
    logic [7:0] v;
    v = UID[8*(c%16)+:8];
    return c >= 512 ? 8'h00 : (c[4] ? ~v : v);
  endfunction
  function automatic logic [7:0] par(input int c);
    case (c % 256)
      151: return 8'h07;
      164, 166, 172, 177: return 8'h01;
      170, 174: return 8'h04;
      171: return 8'h10;
      173: return 8'h81;
      175, 176: return 8'h02;
      178: return 8'h1E;
      default: return 8'h00;
    endcase
  endfunction
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd_d, `CTRL_RESET)
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `REG_UID0 + 8'(4 * k), UID[32*k+:32]);
      apb(1'b0, `REG_UID0 + 8'(4 * k), 32'h0);
      `CHK(rd_d, UID[32*k+:32])
    end
    apb(1'b0, 8'hFC, 32'h0);
    `CHK({rd_e, rd_d}, {1'b1, 32'h0})
    apb(1'b1, `REG_STATUS, 32'hFFFF_FFFF);
    `CHK(rd_e, 1'b1)
    $display("test regs done");
  endtask
  task automatic t_uid;
    logic [7:0] half [16];
    lun_busy <= 1'b1;
    u_host.latch(1'b1, `CMD_UID);
    u_host.latch(1'b0, `UID_ADDR);
    wait_ready(1'b0);
    lun_busy <= 1'b0;
    u_host.latch(1'b1, `CMD_UID);
    u_host.latch(1'b0, `UID_ADDR);
    wait_ready(1'b1);
    for (int c = 0; c < 40; c++) begin
      u_host.rd(b);
      `CHK(b, uid_byte(c))
      if (c < 16) half[c] = b;
      else if (c < 32) `CHK(b ^ half[c - 16], 8'hFF)
    end
    u_host.latch(1'b1, `CMD_STATUS);
    u_host.rd(b);
    `CHK(b, `STAT_READY)
    u_host.latch(1'b1, `CMD_READ_MODE);
    u_host.rd(b);
    `CHK(b, uid_byte(40))
    u_host.col(13'd496);
    for (int c = 496; c < 516; c++) begin
      u_host.rd(b);
      `CHK(b, uid_byte(c))
    end
    $display("test uid done");
  endtask
  task automatic t_param;
    u_host.latch(1'b1, `CMD_PARAM);
    u_host.latch(1'b0, 8'h00);
    wait_ready(1'b1);
    u_host.col(13'd151);
    for (int c = 151; c < 179; c++) begin
      u_host.rd(b);
      `CHK(b, par(c))
    end
    u_host.col(13'd3991);
    u_host.rd(b);
    `CHK(b, 8'h07)
    u_host.col(13'd4096);
    u_host.rd(b);
    `CHK(b, `PARAM_BLANK)
    $display("test param done");
  endtask
  task automatic t_ddr;
    apb(1'b1, `REG_CTRL, 32'h1);
    u_host.latch(1'b1, `CMD_UID);
    u_host.latch(1'b0, `UID_ADDR);
    wait_ready(1'b1);
    strobed.delete();
    u_host.ddr(8);
    `CHK(strobed.size(), 8)
    for (int i = 0; i < strobed.size(); i++) `CHK(strobed[i], uid_byte(i))
    clk_en <= 1'b0;
    u_host.ddr(2);
    `CHK(pready, 1'b0)
    clk_en <= 1'b1;
    apb(1'b0, `REG_COLUMN, 32'h0);
    `CHK(rd_d, 32'h0000_0008)
    u_host.latch(1'b1, `CMD_RESET);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(rd_d[3:0], 4'h1)
    $display("test ddr done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_regs();
    t_uid();
    t_param();
    t_ddr();
    results();
  end
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
endmodule // tb
`default_nettype wire

// ===== uid_param_chk.sv
`timescale 1ns/1ns
`default_nettype none
module uid_param_chk #(
  parameter TR_CYCLES = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe,
  input wire logic rb_out,
  input wire logic rb_oe
);
  localparam int BMIN = TR_CYCLES;
  localparam int BMAX = TR_CYCLES + 3;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RB_LOW: assert property (rb_out == 1'b0) else $error("busy pin drives high");
  AST_PREADY: assert property (pready == clk_en) else $error("pready not clk_en");
  AST_OE_RESET: assert property ($rose(presetn) |-> !dq_oe && !dqs_oe && !rb_oe) else $error("drive after reset");
  AST_BUSY_HOLD: assert property ($rose(rb_oe) |-> rb_oe [*8]) else $error("busy too short");
  AST_BUSY_END: assert property ($rose(rb_oe) |-> ##[BMIN:BMAX] $fell(rb_oe)) else $error("busy length");
  AST_UNMAPPED: assert property (psel && penable && paddr == 8'hFC |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  AST_DQ_OE_CAUSE: assert property ($rose(dq_oe) |-> !ce_n && !cle && !ale) else $error("dq driven");
  AST_DQS_CAUSE: assert property ($changed(dqs_out) |-> !ce_n && !cle && !ale) else $error("stray strobe");
  cover property ($fell(rb_oe));
  cover property ($changed(dqs_out));
  cover property (psel && penable && pslverr);
endmodule // uid_param_chk
bind uid_param_readout uid_param_chk #(.TR_CYCLES(TR_CYCLES)) u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
  .paddr, .pready, .prdata, .pslverr, .ce_n, .cle, .ale, .dq_oe, .dqs_out, .dqs_oe, .rb_out, .rb_oe);
`default_nettype wire

// ===== uid_param_readout.v
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "uid_param_regs.vh"

module uid_param_readout #(
  parameter ADDR_W = 8,
  parameter TR_CYCLES = `TR_CYCLES,
  parameter [15:0] PARAM_CRC = 16'h0000
) (
  // APB clock, reset and enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Array side
  input wire lun_busy,
  // Flash link pins
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire re_n,
  input wire link_clk,
  input wire [7:0] dq_in,
  output reg [7:0] dq_out,
  output reg dq_oe,
  output reg dqs_out,
  output reg dqs_oe,
  output wire rb_out,
  output reg rb_oe
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ADDR = 4'b0010;
  localparam [3:0] ST_BUSY = 4'b0100;
  localparam [3:0] ST_OUT = 4'b1000;
  localparam [1:0] CC_NONE = 2'b00;
  localparam [1:0] CC_LO = 2'b01;
  localparam [1:0] CC_HI = 2'b10;
  localparam [1:0] CC_DONE = 2'b11;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [13:0] pins_s;
  reg we_d_ff;
  reg re_d_ff;
  reg lclk_d_ff;

  sync2 #(.WIDTH(14)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    // Active-low pins go in inverted so the reset value matches their idle level
    .d({~ce_n, cle, ale, ~we_n, ~re_n, link_clk, dq_in}),
    .q(pins_s)
  );

  wire ce_n_s = !pins_s[13];
  wire cle_s = pins_s[12];
  wire ale_s = pins_s[11];
  wire we_n_s = !pins_s[10];
  wire re_n_s = !pins_s[9];
  wire lclk_s = pins_s[8];
  wire [7:0] dq_s = pins_s[7:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_d_ff <= 1'b1;
      re_d_ff <= 1'b1;
      lclk_d_ff <= 1'b0;
    end else if (clk_en) begin
      we_d_ff <= we_n_s;
      re_d_ff <= re_n_s;
      lclk_d_ff <= lclk_s;
    end
  end

  wire sel_s = !ce_n_s;
  wire we_rise = sel_s && we_n_s && !we_d_ff;
  wire re_fall = sel_s && !re_n_s && re_d_ff;
  wire lclk_edge = lclk_s ^ lclk_d_ff;
  wire data_phase = sel_s && !cle_s && !ale_s;

  // ----------------------------------------------------------------
  // Registers and link state
  // ----------------------------------------------------------------
  reg ddr_ff;
  reg [127:0] uid_ff;
  reg [3:0] state_ff;
  reg param_ff;
  reg status_view_ff;
  reg [12:0] col_ff;
  reg [12:0] chg_col_ff;
  reg [1:0] chg_ff;
  reg [31:0] tr_cnt_ff;

  // ----------------------------------------------------------------
  // Parameter page bytes
  // ----------------------------------------------------------------
  function [7:0] param_byte;
    input [7:0] b;
    begin
      case (b)
        8'd151: param_byte = 8'h07;
        8'd164: param_byte = 8'h01;
        8'd166: param_byte = 8'h01;
        8'd170: param_byte = 8'h04;
        8'd171: param_byte = 8'h10;
        8'd172: param_byte = 8'h01;
        8'd173: param_byte = 8'h81;
        8'd174: param_byte = 8'h04;
        8'd175: param_byte = 8'h02;
        8'd176: param_byte = 8'h02;
        8'd177: param_byte = 8'h01;
        8'd178: param_byte = 8'h1E;
        8'd179: param_byte = 8'h90;
        8'd253: param_byte = 8'h01;
        8'd254: param_byte = PARAM_CRC[7:0];
        8'd255: param_byte = PARAM_CRC[15:8];
        default: param_byte = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Byte selection
  // ----------------------------------------------------------------
  reg [7:0] uid_byte;
  reg [7:0] cur_byte;

  always @* begin
    uid_byte = uid_ff[{col_ff[3:0], 3'b000} +: 8];
    if (col_ff[4]) begin
      uid_byte = ~uid_byte;
    end
    if (status_view_ff) begin
      cur_byte = (state_ff == ST_BUSY) ? `STAT_BUSY : `STAT_READY;
    end else if (param_ff) begin
      cur_byte = (col_ff >= `PARAM_END) ? `PARAM_BLANK : param_byte(col_ff[7:0]);
    end else begin
      cur_byte = (col_ff < `UID_END) ? uid_byte : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Command interpreter
  // ----------------------------------------------------------------
  wire out_step = data_phase && !re_n_s && (ddr_ff ? lclk_edge : re_fall);
  wire reading = (state_ff == ST_OUT) || status_view_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      param_ff <= 1'b0;
      status_view_ff <= 1'b0;
      col_ff <= 13'h0000;
      chg_col_ff <= 13'h0000;
      chg_ff <= CC_NONE;
      tr_cnt_ff <= 32'h0000_0000;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
      rb_oe <= 1'b0;
    end else if (clk_en) begin
      if (we_rise && cle_s) begin
        chg_ff <= CC_NONE;
        case (dq_s)
          `CMD_UID, `CMD_PARAM: begin
            if (!lun_busy && state_ff != ST_BUSY) begin
              state_ff <= ST_ADDR;
              param_ff <= (dq_s == `CMD_PARAM);
              status_view_ff <= 1'b0;
            end
          end
          `CMD_STATUS: status_view_ff <= 1'b1;
          `CMD_READ_MODE: status_view_ff <= 1'b0;
          `CMD_CHG_COL: begin
            if (state_ff == ST_OUT) begin
              chg_ff <= CC_LO;
            end
          end
          `CMD_CHG_COL_CONF: begin
            if (chg_ff == CC_DONE) begin
              col_ff <= chg_col_ff;
              status_view_ff <= 1'b0;
            end
          end
          default: begin
            if (state_ff != ST_BUSY) begin
              state_ff <= ST_IDLE;
              status_view_ff <= 1'b0;
            end
          end
        endcase
      end else if (we_rise && ale_s) begin
        if (state_ff == ST_ADDR && dq_s == `UID_ADDR) begin
          state_ff <= ST_BUSY;
          tr_cnt_ff <= TR_CYCLES - 1;
        end
        case (chg_ff)
          CC_LO: begin
            chg_col_ff[7:0] <= dq_s;
            chg_ff <= CC_HI;
          end
          CC_HI: begin
            chg_col_ff[12:8] <= dq_s[4:0];
            chg_ff <= CC_DONE;
          end
          default: chg_ff <= chg_ff;
        endcase
      end else if (state_ff == ST_BUSY) begin
        if (tr_cnt_ff == 32'h0000_0000) begin
          state_ff <= ST_OUT;
          col_ff <= 13'h0000;
        end else begin
          tr_cnt_ff <= tr_cnt_ff - 32'h0000_0001;
        end
      end else if (out_step && reading) begin
        dq_out <= cur_byte;
        if (!status_view_ff) begin
          col_ff <= col_ff + 13'h0001;
        end
        if (ddr_ff) begin
          dqs_out <= ~dqs_out;
        end
      end
      dq_oe <= data_phase && !re_n_s && reading;
      dqs_oe <= ddr_ff && data_phase && !re_n_s && reading;
      rb_oe <= (state_ff == ST_BUSY);
    end
  end

  // Open-drain ready/busy: only ever pulls low
  assign rb_out = 1'b0;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states while clk_en is high; read data is captured in setup so it comes from flops
  assign pready = clk_en;

  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  reg [31:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_hit = 1'b1;
    case (paddr)
      `REG_CTRL: rd_mux = {31'h0, ddr_ff};
      `REG_STATUS: rd_mux = {24'h0, lun_busy, param_ff, status_view_ff, chg_ff[0], state_ff};
      `REG_COLUMN: rd_mux = {19'h0, col_ff};
      `REG_UID0: rd_mux = uid_ff[31:0];
      `REG_UID1: rd_mux = uid_ff[63:32];
      `REG_UID2: rd_mux = uid_ff[95:64];
      `REG_UID3: rd_mux = uid_ff[127:96];
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddr_ff <= 1'b0;
      uid_ff <= `UID_RESET;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !rd_hit || (pwrite && (paddr == `REG_STATUS || paddr == `REG_COLUMN));
      end
      if (apb_wr) begin
        case (paddr)
          `REG_CTRL: ddr_ff <= pwdata[`CTRL_DDR_BIT];
          `REG_UID0: uid_ff[31:0] <= pwdata;
          `REG_UID1: uid_ff[63:32] <= pwdata;
          `REG_UID2: uid_ff[95:64] <= pwdata;
          `REG_UID3: uid_ff[127:96] <= pwdata;
          default: ddr_ff <= ddr_ff;
        endcase
      end
    end
  end

endmodule // uid_param_readout

`default_nettype wire

// ===== uid_param_regs.vh
`ifndef UID_PARAM_REGS_VH
`define UID_PARAM_REGS_VH

// APB register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_COLUMN 8'h08
`define REG_UID0 8'h10
`define REG_UID1 8'h14
`define REG_UID2 8'h18
`define REG_UID3 8'h1C

// Field positions and reset values
`define CTRL_DDR_BIT 0
`define CTRL_RESET 32'h0000_0000
`define UID_RESET 128'h0

// Link command codes
`define CMD_READ_MODE 8'h00
`define CMD_CHG_COL 8'h05
`define CMD_CHG_COL_CONF 8'hE0
`define CMD_STATUS 8'h70
`define CMD_PARAM 8'hEC
`define CMD_UID 8'hED
`define CMD_RESET 8'hFF
`define UID_ADDR 8'h00

// Status byte: write protect off, ready, array ready
`define STAT_READY 8'hE0
`define STAT_BUSY 8'h80

// Unique ID layout
`define UID_COPY_BYTES 32
`define UID_HALF_BYTES 16
`define UID_COPIES 16
`define UID_END 13'd512

// Parameter page layout
`define PARAM_END 13'd4096
`define PARAM_BLANK 8'hFF

// Array page read time
`define TR_US 25
`define CLK_MHZ 100
`define TR_CYCLES (`TR_US * `CLK_MHZ)

`endif
